// [src/rbp_packer.sv]
`default_nettype none
module rbp_packer
  import rbp_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        side_connect_i,
  input  wire logic        scan_i,
  input  wire rbp_rx_t     rx1_i,
  input  wire rbp_rx_t     rx2_i,
  output logic             rx1_ready_o,
  output logic             rx2_ready_o,
  input  wire logic [8:0]  wr1_len_i,
  input  wire logic        wr1_busy_i,
  input  wire logic [8:0]  wr2_len_i,
  input  wire logic        wr2_busy_i,
  output rbp_word_t        out_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic             busy_o,
  output logic [6:0]       seq_o
);
  typedef enum {RBP_S_IDLE, RBP_S_EMIT} rbp_state_t;

  rbp_state_t  st_reg;
  logic        sc_reg;
  logic [8:0]  idx_reg;
  logic [6:0]  seq_reg;
  logic [15:0] len_reg  [2];
  logic [15:0] acc_reg  [2];
  logic [8:0]  seg_reg  [2];
  logic        stat_reg [2];
  logic [15:0] rs_reg   [2];
  logic [15:0] rc_reg   [2];
  logic [15:0] er_reg   [2];

  rbp_rx_t     rx_in    [2];
  logic        rx_rdy   [2];
  logic [15:0] head     [2];
  logic [12:0] avail    [2];
  logic [12:0] count    [2];
  rbp_rx_st_t  rx_st    [2];
  logic        ovf      [2];
  logic [1:0]  pop      [2];
  logic [8:0]  wr_len   [2];
  logic        wr_busy  [2];

  rbp_kind_t   kind;
  logic        port;
  logic        is_dat;
  logic [8:0]  base;
  logic [8:0]  rel;
  logic [9:0]  off;
  logic        lo_ok;
  logic        hi_ok;
  logic [8:0]  area;
  logic [8:0]  last_idx;
  rbp_word_t   word;
  logic        fifo_rdy;
  logic        push;
  logic        start;
  logic        blk_end;

  assign rx_in[0]   = rx1_i;
  assign rx_in[1]   = rx2_i;
  assign rx1_ready_o = rx_rdy[0];
  assign rx2_ready_o = rx_rdy[1];
  assign wr_len[0]  = wr1_len_i;
  assign wr_len[1]  = wr2_len_i;
  assign wr_busy[0] = wr1_busy_i;
  assign wr_busy[1] = wr2_busy_i;

  // scan requests arriving mid-block are dropped, not queued
  assign start   = (st_reg == RBP_S_IDLE) && scan_i;
  assign push    = (st_reg == RBP_S_EMIT) && fifo_rdy;
  assign blk_end = push && word.last;
  assign busy_o  = (st_reg != RBP_S_IDLE);
  assign seq_o   = seq_reg;

  // area and block length follow the live mode at scan time
  assign area     = side_connect_i ? RBP_SC_AREA : RBP_BT_AREA;
  assign last_idx = sc_reg ? RBP_SC_LAST : RBP_BT_LAST;

  // one receive buffer per serial port
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      rbp_rxbuf u_rxbuf (
        .ref_clk_i  (ref_clk_i),
        .resetn_i   (resetn_i),
        .rx_i       (rx_in[p]),
        .rx_ready_o (rx_rdy[p]),
        .pop_i      (pop[p]),
        .head_o     (head[p]),
        .avail_o    (avail[p]),
        .count_o    (count[p]),
        .state_o    (rx_st[p]),
        .ovf_o      (ovf[p])
      );

      // bytes leave the buffer only as they enter a pushed word
      assign pop[p] = (push && is_dat && !stat_reg[p] &&
                       (port == 1'(p))) ?
                      {1'b0, lo_ok} + {1'b0, hi_ok} : 2'h0;

      // segment plan and write report latched per scan
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          len_reg[p]  <= 16'h0000;
          acc_reg[p]  <= 16'h0000;
          seg_reg[p]  <= 9'h000;
          stat_reg[p] <= 1'b1;
        end else if (start) begin
          if (avail[p] > {4'h0, area}) begin
            len_reg[p] <= RBP_LEN_CONT;
            seg_reg[p] <= area;
          end else begin
            len_reg[p] <= {3'h0, avail[p]};
            seg_reg[p] <= avail[p][8:0];
          end
          stat_reg[p] <= (avail[p] == 13'h0000);
          acc_reg[p]  <= wr_busy[p] ? 16'h0000 :
                         {7'h00, wr_len[p]};
        end
      end

      // status snapshot shown when the port has nothing to send
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          rs_reg[p] <= RBP_RS_LISTEN;
          rc_reg[p] <= 16'h0000;
          er_reg[p] <= 16'h0000;
        end else if (start) begin
          case (rx_st[p])
            RBP_RX_RECV: rs_reg[p] <= RBP_RS_RECV;
            RBP_RX_WAIT: rs_reg[p] <= RBP_RS_WAIT;
            default:     rs_reg[p] <= RBP_RS_LISTEN;
          endcase
          rc_reg[p] <= {3'h0, count[p]};
          er_reg[p] <= {15'h0000, ovf[p]};
        end
      end
    end
  endgenerate

  // field lookup for the word now being built
  always_comb begin
    kind   = rbp_decode(idx_reg, sc_reg);
    port   = (kind == RBP_K_LEN2) || (kind == RBP_K_ACC2) ||
             (kind == RBP_K_DAT2);
    is_dat = (kind == RBP_K_DAT1) || (kind == RBP_K_DAT2);
    if (port) begin
      base = sc_reg ? RBP_SC_DAT2 : RBP_BT_DAT2;
    end else begin
      base = RBP_W_DAT1;
    end
    rel   = idx_reg - base;
    off   = {rel, 1'b0};
    lo_ok = off < {1'b0, seg_reg[port]};
    hi_ok = (off + 10'h001) < {1'b0, seg_reg[port]};
  end

  // word contents; unused bytes and reserved words stay zero
  always_comb begin
    word.idx  = idx_reg;
    word.last = (idx_reg == last_idx);
    word.data = 16'h0000;
    case (kind)
      RBP_K_SEQ:  word.data = {9'h000, seq_reg};
      RBP_K_LEN1,
      RBP_K_LEN2: word.data = len_reg[port];
      RBP_K_ACC1,
      RBP_K_ACC2: word.data = acc_reg[port];
      RBP_K_DAT1,
      RBP_K_DAT2: begin
        if (stat_reg[port]) begin
          if (rel == RBP_ST_STATE) begin
            word.data = rs_reg[port];
          end else if (rel == RBP_ST_COUNT) begin
            word.data = rc_reg[port];
          end else if (rel == RBP_ST_ERR) begin
            word.data = er_reg[port];
          end
        end else begin
          // lower byte offset rides in the low half
          if (lo_ok) word.data[7:0]  = head[port][7:0];
          if (hi_ok) word.data[15:8] = head[port][15:8];
        end
      end
      default:    word.data = 16'h0000;
    endcase
  end

  // block walker: one word per cycle while the fifo has room
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg  <= RBP_S_IDLE;
      idx_reg <= 9'h000;
      sc_reg  <= 1'b0;
    end else begin
      case (st_reg)
        RBP_S_IDLE: begin
          if (start) begin
            st_reg  <= RBP_S_EMIT;
            idx_reg <= 9'h000;
            sc_reg  <= side_connect_i;
          end
        end
        RBP_S_EMIT: begin
          if (blk_end) begin
            st_reg <= RBP_S_IDLE;
          end else if (push) begin
            idx_reg <= idx_reg + 9'h001;
          end
        end
        default: st_reg <= RBP_S_IDLE;
      endcase
    end
  end

  // sequence steps once per finished block so each one differs
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_reg <= 7'h00;
    end else if (blk_end) begin
      if (seq_reg == RBP_SEQ_MAX) begin
        seq_reg <= 7'h00;
      end else begin
        seq_reg <= seq_reg + 7'h01;
      end
    end
  end

  // short buffer decouples the walker from backplane stalls
  rbp_fifo #(
    .W     ($bits(rbp_word_t)),
    .DEPTH (RBP_FIFO_DEP)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_data_i   (word),
    .in_valid_i  (st_reg == RBP_S_EMIT),
    .in_ready_o  (fifo_rdy),
    .out_data_o  (out_o),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i)
  );

  sequence blk_done_s;
    blk_end && seq_reg != RBP_SEQ_MAX;
  endsequence

  seq_step_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    blk_done_s |=> seq_reg == $past(seq_reg) + 7'h01)
    else $error("sequence did not advance by one");

  seq_wrap_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    blk_end && seq_reg == RBP_SEQ_MAX |=> seq_reg == 7'h00)
    else $error("sequence did not wrap to zero");

  seq_word_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    push && idx_reg == RBP_W_SEQ |-> word.data == {9'h000, seq_reg})
    else $error("word 0 does not carry the sequence");

  cont_len_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    start && avail[0] > {4'h0, area}
    |=> len_reg[0] == RBP_LEN_CONT && seg_reg[0] == $past(area))
    else $error("continuation segment not marked -1 full");

  final_len_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    start && avail[1] <= {4'h0, area}
    |=> len_reg[1] == {3'h0, $past(avail[1])})
    else $error("final segment length mismatch");

  busy_acc_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    start && wr1_busy_i |=> acc_reg[0] == 16'h0000)
    else $error("busy port reported accepted bytes");

  rsv_zero_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    push && kind == RBP_K_RSV |-> word.data == 16'h0000)
    else $error("reserved word not zero");

  blk_size_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    blk_end |-> idx_reg == (sc_reg ? RBP_SC_LAST : RBP_BT_LAST))
    else $error("block length wrong for interface form");

  seg_pop_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    push && is_dat && !stat_reg[port] && !lo_ok |-> word.data == 16'h0000)
    else $error("bytes beyond segment length");
endmodule : rbp_packer
`default_nettype wire

// [include/rbp_pkg.sv]
`default_nettype none
package rbp_pkg;
  localparam logic [8:0]  RBP_BT_LAST  = 9'h03F; // word 63
  localparam logic [8:0]  RBP_SC_LAST  = 9'h1F3; // word 499
  localparam logic [8:0]  RBP_BT_AREA  = 9'h032; // 50 bytes
  localparam logic [8:0]  RBP_SC_AREA  = 9'h190; // 400 bytes
  localparam logic [8:0]  RBP_W_SEQ    = 9'h000;
  localparam logic [8:0]  RBP_W_LEN1   = 9'h001;
  localparam logic [8:0]  RBP_W_ACC1   = 9'h002;
  localparam logic [8:0]  RBP_W_DAT1   = 9'h003;
  localparam logic [8:0]  RBP_BT_LEN2  = 9'h01C; // 28
  localparam logic [8:0]  RBP_BT_ACC2  = 9'h01D; // 29
  localparam logic [8:0]  RBP_BT_DAT2  = 9'h01E; // 30
  localparam logic [8:0]  RBP_BT_RSV   = 9'h037; // 55
  localparam logic [8:0]  RBP_SC_LEN2  = 9'h0CB; // 203
  localparam logic [8:0]  RBP_SC_ACC2  = 9'h0CC; // 204
  localparam logic [8:0]  RBP_SC_DAT2  = 9'h0CD; // 205
  localparam logic [8:0]  RBP_SC_RSV   = 9'h195; // 405
  localparam logic [6:0]  RBP_SEQ_MAX  = 7'h7F;
  localparam int          RBP_BUF_DEP  = 4096;
  localparam logic [12:0] RBP_BUF_FULL = 13'h1000;
  localparam logic [15:0] RBP_LEN_CONT = 16'hFFFF; // -1
  localparam logic [15:0] RBP_RS_LISTEN = 16'hFFFF;
  localparam logic [15:0] RBP_RS_RECV   = 16'h0001;
  localparam logic [15:0] RBP_RS_WAIT   = 16'h0002;
  localparam logic [8:0]  RBP_ST_STATE = 9'h000;
  localparam logic [8:0]  RBP_ST_COUNT = 9'h001;
  localparam logic [8:0]  RBP_ST_ERR   = 9'h002;
  localparam int          RBP_FIFO_DEP = 4;

  typedef enum {RBP_K_SEQ, RBP_K_LEN1, RBP_K_ACC1, RBP_K_DAT1,
                RBP_K_LEN2, RBP_K_ACC2, RBP_K_DAT2, RBP_K_RSV
               } rbp_kind_t;

  typedef enum {RBP_RX_LISTEN, RBP_RX_RECV, RBP_RX_WAIT} rbp_rx_st_t;

  // one serial character from the port framer
  typedef struct packed {
    logic       valid;
    logic       term;  // termination seen with this character
    logic [7:0] data;
  } rbp_rx_t;

  // one word of a read block on its way to the backplane
  typedef struct packed {
    logic        last;
    logic [8:0]  idx;
    logic [15:0] data;
  } rbp_word_t;

  // word index to field, for either interface form
  function automatic rbp_kind_t rbp_decode(input logic [8:0] i,
                                           input logic       sc);
    logic [8:0] l2;
    logic [8:0] a2;
    logic [8:0] rv;
    l2 = sc ? RBP_SC_LEN2 : RBP_BT_LEN2;
    a2 = sc ? RBP_SC_ACC2 : RBP_BT_ACC2;
    rv = sc ? RBP_SC_RSV : RBP_BT_RSV;
    if (i == RBP_W_SEQ)       return RBP_K_SEQ;
    else if (i == RBP_W_LEN1) return RBP_K_LEN1;
    else if (i == RBP_W_ACC1) return RBP_K_ACC1;
    else if (i < l2)          return RBP_K_DAT1;
    else if (i == l2)         return RBP_K_LEN2;
    else if (i == a2)         return RBP_K_ACC2;
    else if (i < rv)          return RBP_K_DAT2;
    else                      return RBP_K_RSV;
  endfunction : rbp_decode
endpackage : rbp_pkg
`default_nettype wire

// [src/rbp_fifo.sv]
`default_nettype none
module rbp_fifo
  import rbp_pkg::*;
#(
  parameter int W     = 26,
  parameter int DEPTH = RBP_FIFO_DEP
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // honest flags straight from the occupancy
  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem[rd_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  // storage has no reset; only pointers and occupancy need a defined value
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i) cnt_reg <= (AW+1)'(DEPTH))
    else $error("fifo occupancy beyond depth");
endmodule : rbp_fifo
`default_nettype wire

// [src/rbp_rxbuf.sv]
`default_nettype none
module rbp_rxbuf
  import rbp_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire rbp_rx_t     rx_i,
  output logic             rx_ready_o,
  input  wire logic [1:0]  pop_i,
  output logic [15:0]      head_o,
  output logic [12:0]      avail_o,
  output logic [12:0]      count_o,
  output rbp_rx_st_t       state_o,
  output logic             ovf_o
);
  logic [7:0]  mem [RBP_BUF_DEP];
  logic [11:0] wr_reg;
  logic [11:0] rd_reg;
  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;
  rbp_rx_st_t  st_reg;
  logic        ovf_reg;
  logic        push;

  // new message held off until the old one has left
  assign rx_ready_o = (st_reg != RBP_RX_WAIT);
  assign push      = rx_i.valid & rx_ready_o;
  assign cnt_next  = cnt_reg + 13'(push) - 13'(pop_i);
  assign avail_o   = (st_reg == RBP_RX_WAIT) ? cnt_reg : 13'h0000;
  assign count_o   = cnt_reg;
  assign state_o   = st_reg;
  assign ovf_o     = ovf_reg;
  assign head_o    = {mem[rd_reg + 12'h001], mem[rd_reg]};

  // character store, one byte per push
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_reg] <= rx_i.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 12'h001;
      rd_reg  <= rd_reg + 12'(pop_i);
      cnt_reg <= cnt_next;
    end
  end

  // a full buffer counts as a size-limit termination
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= RBP_RX_LISTEN;
    end else begin
      case (st_reg)
        RBP_RX_LISTEN, RBP_RX_RECV: begin
          if (push && (rx_i.term || cnt_next == RBP_BUF_FULL)) begin
            st_reg <= RBP_RX_WAIT;
          end else if (push) begin
            st_reg <= RBP_RX_RECV;
          end
        end
        RBP_RX_WAIT: begin
          if (cnt_next == 13'h0000) st_reg <= RBP_RX_LISTEN;
        end
        default: st_reg <= RBP_RX_LISTEN;
      endcase
    end
  end

  // characters lost while waiting; sticky until reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovf_reg <= 1'b0;
    end else if (rx_i.valid && !rx_ready_o) begin
      ovf_reg <= 1'b1;
    end
  end

  rx_cap_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i) cnt_reg <= RBP_BUF_FULL)
    else $error("receive buffer beyond 4096 bytes");

  hold_msg_a: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (st_reg != RBP_RX_WAIT) |-> pop_i == 2'h0)
    else $error("bytes taken before termination");
endmodule : rbp_rxbuf
`default_nettype wire

// [sim/rbp_host.sv]
`default_nettype none
module rbp_host
  import rbp_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire logic      resetn_i,
  input  wire rbp_word_t out_i,
  input  wire logic      out_valid_i,
  output logic           out_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [0:511];
  logic [9:0]  cnt;
  logic        done;
  logic        fresh;
  logic [15:0] prev_seq;
  logic [1:0]  stall;
  logic [15:0] wr_word0; // first word of the write file

  // refuse one beat in four so the fifo really backs up
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stall <= 2'h0;
    end else begin
      stall <= stall + 2'h1;
    end
  end
  assign out_ready_o = (stall != 2'h3);

  // take each offered word; a block ends on its last word
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt      <= 10'h000;
      done     <= 1'b0;
      fresh    <= 1'b0;
      prev_seq <= 16'hFFFF; // outside 0..127, so block one is new
      wr_word0 <= 16'h0000;
    end else if (out_valid_i && out_ready_o) begin
      mem[out_i.idx] <= out_i.data;
      cnt            <= done ? 10'h001 : cnt + 10'h001;
      done           <= out_i.last;
      if (out_i.last) begin
        fresh    <= (mem[0] != prev_seq);
        prev_seq <= mem[0];
        // hand the files back once the block has been handled
        wr_word0 <= mem[0];
      end
    end
  end
endmodule : rbp_host
`default_nettype wire

// [sim/backplane_read_block_packer_test.sv]
`default_nettype none
module backplane_read_block_packer_test
  import rbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic       sc;
    int         n1;
    int         n2;
    logic       t1;
    logic [8:0] w1;
    logic       b1;
    logic [8:0] w2;
    logic       b2;
    int         nb;
  } rbp_row_t;

  logic       ref_clk_i;
  logic       resetn_i;
  logic       side_connect_i;
  logic       scan_i;
  rbp_rx_t    rx1_i;
  rbp_rx_t    rx2_i;
  logic       rx1_ready_o;
  logic       rx2_ready_o;
  logic [8:0] wr1_len_i;
  logic       wr1_busy_i;
  logic [8:0] wr2_len_i;
  logic       wr2_busy_i;
  rbp_word_t  out_o;
  logic       out_valid_o;
  logic       out_ready_i;
  logic       busy_o;
  logic [6:0] seq_o;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         cycles = 0;
  int         seq = 0;
  int         nb;
  int         rem [2];
  int         off [2];
  int         bc [2] = '{0, 0};
  logic [15:0] st [2] = '{16'hFFFF, 16'hFFFF};
  logic       err [2] = '{1'b0, 1'b0};

  // lengths straddle both data areas; row 3 repeats a refused write
  rbp_row_t rows [5] = '{
    '{1'b0, 0, 0, 1'b1, 9'h00A, 1'b0, 9'h032, 1'b0, 1},
    '{1'b0, 50, 51, 1'b1, 9'h007, 1'b1, 9'h000, 1'b0, 2},
    '{1'b0, 101, 1, 1'b1, 9'h007, 1'b0, 9'h003, 1'b1, 3},
    '{1'b1, 400, 401, 1'b1, 9'h190, 1'b0, 9'h000, 1'b0, 2},
    '{1'b1, 4096, 7, 1'b0, 9'h001, 1'b0, 9'h18F, 1'b1, 11}
  };

  rbp_packer rbp_packer_i (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .side_connect_i(side_connect_i), .scan_i(scan_i),
    .rx1_i(rx1_i), .rx2_i(rx2_i),
    .rx1_ready_o(rx1_ready_o), .rx2_ready_o(rx2_ready_o),
    .wr1_len_i(wr1_len_i), .wr1_busy_i(wr1_busy_i),
    .wr2_len_i(wr2_len_i), .wr2_busy_i(wr2_busy_i),
    .out_o(out_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .busy_o(busy_o), .seq_o(seq_o)
  );

  rbp_host rbp_host_i (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .out_i(out_o),
    .out_valid_i(out_valid_o), .out_ready_o(out_ready_i)
  );

  always #5 ref_clk_i = ~ref_clk_i;

  task report_and_stop();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // a hang counts as a mismatch
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // message byte o of port p; ports differ so swaps show
  function automatic logic [7:0] bexp(input int p, input int o);
    return (p == 0) ? o[7:0] : o[7:0] ^ 8'h5A;
  endfunction : bexp

  task automatic send(input int p, input int s, input int n, input logic t);
    rbp_rx_t c;
    for (int i = s; i < s + n; i++) begin
      c = '{1'b1, t && (i == s + n - 1), bexp(p, i)};
      if (p == 0) rx1_i <= c;
      else rx2_i <= c;
      @(posedge ref_clk_i);
    end
    if (p == 0) rx1_i <= '0;
    else rx2_i <= '0;
  endtask : send

  task automatic chk_port(input int p, input logic [8:0] lw);
    int          n;
    int          area;
    logic [15:0] e;
    area = side_connect_i ? 400 : 50;
    n = (rem[p] > area) ? area : rem[p];
    e = (rem[p] > area) ? RBP_LEN_CONT : 16'(n);
    cmp(rbp_host_i.mem[lw], e);
    e = (p == 0) ? (wr1_busy_i ? 16'h0000 : 16'(wr1_len_i)) :
                   (wr2_busy_i ? 16'h0000 : 16'(wr2_len_i));
    cmp(rbp_host_i.mem[lw + 9'h001], e);
    for (int k = 0; k < area / 2; k++) begin
      e = {(2 * k + 1 < n) ? bexp(p, off[p] + 2 * k + 1) : 8'h00,
           (2 * k < n) ? bexp(p, off[p] + 2 * k) : 8'h00};
      if (n == 0) e = (k == 0) ? st[p] : (k == 1) ? 16'(bc[p]) :
                      (k == 2) ? 16'(err[p]) : 16'h0000;
      cmp(rbp_host_i.mem[lw + 9'(k + 2)], e);
    end
    off[p] += n;
    rem[p] -= n;
  endtask : chk_port

  // one scan, then the whole block is checked as the host saw it
  task automatic blk();
    logic [8:0] lst;
    lst = side_connect_i ? RBP_SC_LAST : RBP_BT_LAST;
    @(posedge ref_clk_i);
    scan_i <= 1'b1;
    @(posedge ref_clk_i);
    scan_i <= 1'b0;
    for (int i = 0; i < 8 && rbp_host_i.done !== 1'b0; i++)
      @(posedge ref_clk_i);
    for (int i = 0; i < 1000 && rbp_host_i.done !== 1'b1; i++)
      @(posedge ref_clk_i);
    cmp(16'(rbp_host_i.cnt), 16'(lst) + 16'h0001);
    cmp(rbp_host_i.mem[0], 16'(seq));
    cmp(16'(rbp_host_i.fresh), 16'h0001);
    if (side_connect_i) cmp(rbp_host_i.wr_word0, 16'(seq));
    chk_port(0, RBP_W_LEN1);
    chk_port(1, side_connect_i ? RBP_SC_LEN2 : RBP_BT_LEN2);
    for (int k = int'(side_connect_i ? RBP_SC_RSV : RBP_BT_RSV);
         k <= int'(lst); k++)
      cmp(rbp_host_i.mem[k], 16'h0000);
    seq = (seq == 127) ? 0 : seq + 1;
    cmp(16'(seq_o), 16'(seq));
  endtask : blk

  initial begin
    ref_clk_i = 1'b0;
    resetn_i = 1'b0;
    side_connect_i = 1'b0;
    scan_i = 1'b0;
    rx1_i = '0;
    rx2_i = '0;
    wr1_len_i = 9'h000;
    wr1_busy_i = 1'b0;
    wr2_len_i = 9'h000;
    wr2_busy_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    cmp(16'({busy_o, out_valid_o, seq_o, rx1_ready_o, rx2_ready_o}),
        16'h0003);
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      side_connect_i <= rows[r].sc;
      wr1_len_i <= rows[r].w1;
      wr1_busy_i <= rows[r].b1;
      wr2_len_i <= rows[r].w2;
      wr2_busy_i <= rows[r].b2;
      send(0, 0, rows[r].n1, rows[r].t1);
      send(1, 0, rows[r].n2, 1'b1);
      rem = '{rows[r].n1, rows[r].n2};
      off = '{0, 0};
      nb = 0;
      do begin
        blk();
        nb++;
      end while (rem[0] + rem[1] > 0 && nb < 20);
      cmp(16'(nb), 16'(rows[r].nb));
    end
    // unterminated message stays in the buffer, status shows it
    side_connect_i <= 1'b0;
    send(0, 0, 5, 1'b0);
    st[0] = 16'h0001;
    bc[0] = 5;
    rem = '{0, 0};
    blk();
    st[0] = 16'hFFFF;
    bc[0] = 0;
    send(0, 5, 1, 1'b1);
    @(posedge ref_clk_i);
    cmp(16'(rx1_ready_o), 16'h0000);
    // a character pushed while refused must flag overflow
    rx1_i <= '{1'b1, 1'b0, 8'hEE};
    @(posedge ref_clk_i);
    rx1_i <= '0;
    err[0] = 1'b1;
    rem = '{6, 0};
    off = '{0, 0};
    blk();
    for (int i = 0; i < 130; i++) blk();
    report_and_stop();
  end
endmodule : backplane_read_block_packer_test
`default_nettype wire
